//--- common/xfer_arith_pkg.sv
// Package of operation codes, sizes, flag layout and datapath types for the arithmetic unit
package xfer_arith_pkg;

  localparam int          NUM_REGS      = 8;
  localparam int          REG_IDX_W     = 3;
  localparam logic [2:0]  STACK_REG_IDX = 3'h7;
  localparam logic [31:0] REG_RESET     = 32'h0000_0000;
  localparam logic [3:0]  FLAGS_RESET   = 4'h0;
  localparam logic [31:0] STEP_BYTE     = 32'h0000_0001;
  localparam logic [31:0] STEP_WORD     = 32'h0000_0002;
  localparam logic [31:0] STEP_LONG     = 32'h0000_0004;
  localparam logic [7:0]  BCD_LOW_FIX   = 8'h06;
  localparam logic [7:0]  BCD_HIGH_FIX  = 8'h60;
  localparam logic [3:0]  BCD_DIGIT_MAX = 4'h9;
  localparam logic [7:0]  BCD_BYTE_MAX  = 8'h99;

  // Flag bit positions in the condition flags word
  localparam int FLAG_C = 0;
  localparam int FLAG_V = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_N = 3;
  localparam int FLAG_H = 4;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'h0,
    SIZE_WORD = 2'h1,
    SIZE_LONG = 2'h2
  } op_size_t;

  typedef enum logic [4:0] {
    OP_NOP          = 5'h00,
    OP_MOVE_REG     = 5'h01,
    OP_MOVE_IMM     = 5'h02,
    OP_LOAD_MEM     = 5'h03,
    OP_STORE_MEM    = 5'h04,
    OP_POP          = 5'h05,
    OP_PUSH         = 5'h06,
    OP_PLUS         = 5'h07,
    OP_MINUS        = 5'h08,
    OP_PLUS_CARRY   = 5'h09,
    OP_MINUS_BORROW = 5'h0a,
    OP_STEP_UP      = 5'h0b,
    OP_STEP_DOWN    = 5'h0c,
    OP_ADDR_PLUS    = 5'h0d,
    OP_ADDR_MINUS   = 5'h0e,
    OP_DEC_ADJ_PLUS = 5'h0f,
    OP_DEC_ADJ_MIN  = 5'h10,
    OP_MUL_U        = 5'h11,
    OP_MUL_S        = 5'h12,
    OP_DIV_U        = 5'h13,
    OP_DIV_S        = 5'h14,
    OP_COMPARE      = 5'h15,
    OP_NEGATE       = 5'h16,
    OP_SIGN_EXT     = 5'h17,
    OP_ZERO_EXT     = 5'h18,
    OP_PERIPH_READ  = 5'h19,
    OP_PERIPH_WRITE = 5'h1a
  } op_code_t;

  // One instruction as issued by the decoder
  typedef struct packed {
    op_code_t              op;
    op_size_t              size;
    logic [REG_IDX_W-1:0]  dst;
    logic [REG_IDX_W-1:0]  src;
    logic                  use_imm;
    logic [31:0]           imm;
  } issue_t;

  // Memory request toward the bus unit
  typedef struct packed {
    logic        req;
    logic        write;
    op_size_t    size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_t;

  // Memory answer from the bus unit
  typedef struct packed {
    logic        done;
    logic [31:0] rdata;
  } mem_rsp_t;

endpackage : xfer_arith_pkg

//--- verilog/xfer_arith_unit.sv
// Transfer and arithmetic execution unit with register file and condition flags
`timescale 1ns/1ps

// Overview of operation
// - Move register, memory or immediate at B/W/L
// - Peripheral-synchronised moves are rejected, no effect
// - Pop loads from stack, then stack pointer grows
// - Push shrinks stack pointer, then stores register
// - Plus and minus on B/W/L, register or immediate
// - Byte minus with immediate is rejected
// - Carry add and borrow subtract, byte only
// - Step by one or two; bytes by one
// - Address step 1, 2 or 4, longword
// - Decimal adjust byte after plus or minus
// - Unsigned multiply 8x8 or 16x16
// - Signed multiply 8x8 or 16x16
// - Unsigned divide 16/8 or 32/16
// - Signed divide, same widths, remainder high
// - Compare updates flags only
// - Negate replaces register with zero minus it
// - Sign extend low byte or low word
// - Zero extend low byte or low word
// - Eight 32-bit general registers, last is stack
// - Flags hold negative, zero, overflow, carry, half carry
module xfer_arith_unit
  import xfer_arith_pkg::*;
(
  input  wire logic        core_clk,
  input  wire issue_t      issue,
  input  wire logic        issue_valid,
  input  wire mem_rsp_t    mem_rsp,
  input  wire logic        rst,
  output logic             issue_ready,
  output logic             illegal_op,
  output mem_req_t         mem_req,
  output logic [4:0]       condition_flags,
  output logic [31:0]      stack_pointer
);

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_MEM  = 2'b10
  } state_t;

  state_t         state;
  logic [31:0]    regs [NUM_REGS];
  issue_t         held;
  logic [4:0]     flags;

  // Mask a value to the operand size
  function automatic logic [31:0] size_mask(input op_size_t s, input logic [31:0] v);
    size_mask = (s == SIZE_BYTE) ? {24'h000000, v[7:0]} :
                (s == SIZE_WORD) ? {16'h0000, v[15:0]} : v;
  endfunction : size_mask

  // Sign bit of a value at the operand size
  function automatic logic top_bit(input op_size_t s, input logic [31:0] v);
    top_bit = (s == SIZE_BYTE) ? v[7] : (s == SIZE_WORD) ? v[15] : v[31];
  endfunction : top_bit

  // Carry out of the sized field of a 33-bit sum
  function automatic logic carry_out(input op_size_t s, input logic [32:0] x,
                                     input logic [31:0] a, input logic [31:0] b);
    logic [32:0] t;
    t = {1'b0, size_mask(s, a)} + {1'b0, size_mask(s, b)} + {32'h0, x[0]};
    carry_out = (s == SIZE_BYTE) ? t[8] : (s == SIZE_WORD) ? t[16] : t[32];
  endfunction : carry_out

  // Merge a sized result into the old register contents
  function automatic logic [31:0] merge(input op_size_t s, input logic [31:0] old,
                                        input logic [31:0] v);
    merge = (s == SIZE_BYTE) ? {old[31:8], v[7:0]} :
            (s == SIZE_WORD) ? {old[31:16], v[15:0]} : v;
  endfunction : merge

  // Operand selection
  wire logic [31:0] dst_val  = regs[issue.dst];
  wire logic [31:0] src_val  = issue.use_imm ? issue.imm : regs[issue.src];
  wire logic [31:0] sp_val   = regs[STACK_REG_IDX];
  wire logic        carry_in = flags[FLAG_C];
  wire op_size_t    sz       = issue.size;

  // Step amount for the push and pop address update
  wire logic [31:0] stack_step = (sz == SIZE_LONG) ? STEP_LONG : STEP_WORD;

  // Legality; a rejected instruction leaves registers and flags untouched
  wire logic is_periph   = (issue.op == OP_PERIPH_READ) || (issue.op == OP_PERIPH_WRITE);
  wire logic byte_imm_sub = (issue.op == OP_MINUS) && issue.use_imm && (sz == SIZE_BYTE);
  wire logic carry_wide  = ((issue.op == OP_PLUS_CARRY) || (issue.op == OP_MINUS_BORROW))
                           && (sz != SIZE_BYTE);
  wire logic step_bad    = ((issue.op == OP_STEP_UP) || (issue.op == OP_STEP_DOWN)) &&
                           (((sz == SIZE_BYTE) && (issue.imm != STEP_BYTE)) ||
                            ((issue.imm != STEP_BYTE) && (issue.imm != STEP_WORD)));
  wire logic addr_bad    = ((issue.op == OP_ADDR_PLUS) || (issue.op == OP_ADDR_MINUS)) &&
                           ((issue.imm != STEP_BYTE) && (issue.imm != STEP_WORD) &&
                            (issue.imm != STEP_LONG));
  wire logic stack_bad   = ((issue.op == OP_PUSH) || (issue.op == OP_POP)) && (sz == SIZE_BYTE);
  wire logic muldiv_long = ((issue.op == OP_MUL_U) || (issue.op == OP_MUL_S) ||
                            (issue.op == OP_DIV_U) || (issue.op == OP_DIV_S)) &&
                           (sz == SIZE_LONG);
  wire logic ext_byte    = ((issue.op == OP_SIGN_EXT) || (issue.op == OP_ZERO_EXT)) &&
                           (sz == SIZE_BYTE);
  wire logic dec_wide    = ((issue.op == OP_DEC_ADJ_PLUS) || (issue.op == OP_DEC_ADJ_MIN)) &&
                           (sz != SIZE_BYTE);
  wire logic reject      = is_periph || byte_imm_sub || carry_wide || step_bad ||
                           addr_bad || stack_bad || muldiv_long || ext_byte || dec_wide;
  wire logic take        = issue_valid && (state == ST_IDLE);
  wire logic exec        = take && !reject;

  // Adder operands: subtraction adds the inverted source plus one
  wire logic is_sub  = (issue.op == OP_MINUS) || (issue.op == OP_MINUS_BORROW) ||
                       (issue.op == OP_COMPARE) || (issue.op == OP_STEP_DOWN) ||
                       (issue.op == OP_NEGATE);
  wire logic use_cy  = (issue.op == OP_PLUS_CARRY) || (issue.op == OP_MINUS_BORROW);
  wire logic [31:0] add_a = (issue.op == OP_NEGATE) ? 32'h0000_0000 : dst_val;
  wire logic [31:0] add_b_raw = (issue.op == OP_NEGATE) ? dst_val :
                                ((issue.op == OP_STEP_UP) || (issue.op == OP_STEP_DOWN)) ?
                                issue.imm : src_val;
  wire logic [31:0] add_b = is_sub ? ~add_b_raw : add_b_raw;
  wire logic        add_x = use_cy ? (is_sub ? ~carry_in : carry_in) : is_sub;
  wire logic [31:0] sum   = add_a + add_b + {31'h0, add_x};
  wire logic [31:0] sum_m = size_mask(sz, sum);
  wire logic        cy_raw = carry_out(sz, {32'h0, add_x}, add_a, add_b);
  wire logic        sa = top_bit(sz, add_a);
  wire logic        sb = top_bit(sz, add_b);
  wire logic        sr = top_bit(sz, sum);
  wire logic        ovf = (sa == sb) && (sr != sa);
  wire logic        cy  = is_sub ? ~cy_raw : cy_raw;
  wire logic        hc  = (add_a[3:0] + add_b[3:0] + {3'h0, add_x}) > 5'h0f;

  // Address steps, longword and flag-neutral
  wire logic [31:0] addr_res = (issue.op == OP_ADDR_PLUS) ? dst_val + issue.imm :
                               dst_val - issue.imm;

  // Decimal adjust from carry and half carry of the previous byte result
  wire logic [7:0]  bcd_in  = dst_val[7:0];
  wire logic        fix_lo  = flags[FLAG_H] || (bcd_in[3:0] > BCD_DIGIT_MAX);
  wire logic        fix_hi  = carry_in || (bcd_in > BCD_BYTE_MAX);
  wire logic [7:0]  bcd_fix = (fix_lo ? BCD_LOW_FIX : 8'h00) | (fix_hi ? BCD_HIGH_FIX : 8'h00);
  wire logic [7:0]  bcd_res = (issue.op == OP_DEC_ADJ_PLUS) ? bcd_in + bcd_fix :
                              bcd_in - bcd_fix;

  // Multiply: byte form uses low bytes, word form low words
  wire logic [15:0] mul_a   = (sz == SIZE_BYTE) ? {8'h00, dst_val[7:0]} : dst_val[15:0];
  wire logic [15:0] mul_b   = (sz == SIZE_BYTE) ? {8'h00, regs[issue.src][7:0]} :
                              regs[issue.src][15:0];
  wire logic [31:0] mul_u   = mul_a * mul_b;
  wire logic [15:0] mul_s8  = 16'($signed(dst_val[7:0]) * $signed(regs[issue.src][7:0]));
  wire logic [31:0] mul_s16 = 32'($signed(dst_val[15:0]) * $signed(regs[issue.src][15:0]));
  wire logic [31:0] mul_s   = (sz == SIZE_BYTE) ? {16'h0000, mul_s8} : mul_s16;

  // Divide: remainder in the upper half, quotient in the lower half
  wire logic [31:0] dvd   = (sz == SIZE_BYTE) ? {16'h0000, dst_val[15:0]} : dst_val;
  wire logic [15:0] dvs   = (sz == SIZE_BYTE) ? {8'h00, regs[issue.src][7:0]} :
                            regs[issue.src][15:0];
  wire logic        dvs_zero = (dvs == 16'h0000);
  // A zero divisor returns zero rather than trapping; software must test first
  wire logic [31:0] q_u   = dvs_zero ? 32'h0 : dvd / {16'h0000, dvs};
  wire logic [31:0] r_u   = dvs_zero ? 32'h0 : dvd % {16'h0000, dvs};
  wire logic [31:0] div_u = (sz == SIZE_BYTE) ? {16'h0000, r_u[7:0], q_u[7:0]} :
                            {r_u[15:0], q_u[15:0]};
  wire logic signed [31:0] dvd_s = (sz == SIZE_BYTE) ? 32'($signed(dst_val[15:0])) :
                                   $signed(dst_val);
  wire logic signed [31:0] dvs_s = (sz == SIZE_BYTE) ? 32'($signed(regs[issue.src][7:0])) :
                                   32'($signed(regs[issue.src][15:0]));
  wire logic signed [31:0] q_s   = dvs_zero ? 32'sh0 : dvd_s / dvs_s;
  wire logic signed [31:0] r_s   = dvs_zero ? 32'sh0 : dvd_s % dvs_s;
  wire logic [31:0] div_s = (sz == SIZE_BYTE) ? {16'h0000, r_s[7:0], q_s[7:0]} :
                            {r_s[15:0], q_s[15:0]};
  wire logic        div_res_n = (sz == SIZE_BYTE) ? q_s[7] : q_s[15];

  // Extensions of the low half
  wire logic [31:0] ext_s = (sz == SIZE_WORD) ? {dst_val[31:16], {8{dst_val[7]}}, dst_val[7:0]} :
                            {{16{dst_val[15]}}, dst_val[15:0]};
  wire logic [31:0] ext_z = (sz == SIZE_WORD) ? {dst_val[31:16], 8'h00, dst_val[7:0]} :
                            {16'h0000, dst_val[15:0]};

  // Result selection and write enable toward the destination register
  logic [31:0] next_dst;
  logic        write_dst;
  logic [4:0]  next_flags;
  always_comb begin
    next_dst   = dst_val;
    write_dst  = 1'b0;
    next_flags = flags;
    unique case (issue.op)
      OP_MOVE_REG, OP_MOVE_IMM: begin
        next_dst  = merge(sz, dst_val, src_val);
        write_dst = 1'b1;
        next_flags[FLAG_N] = top_bit(sz, src_val);
        next_flags[FLAG_Z] = (size_mask(sz, src_val) == 32'h0);
        next_flags[FLAG_V] = 1'b0;
      end
      OP_PLUS, OP_MINUS, OP_PLUS_CARRY, OP_MINUS_BORROW, OP_COMPARE, OP_NEGATE,
      OP_STEP_UP, OP_STEP_DOWN: begin
        next_dst  = merge(sz, dst_val, sum);
        write_dst = (issue.op != OP_COMPARE);
        next_flags[FLAG_N] = sr;
        // Carry-chain forms only clear zero, so multi-byte results test as a whole
        next_flags[FLAG_Z] = use_cy ? (flags[FLAG_Z] && (sum_m == 32'h0)) : (sum_m == 32'h0);
        next_flags[FLAG_V] = ovf;
        if ((issue.op != OP_STEP_UP) && (issue.op != OP_STEP_DOWN)) begin
          next_flags[FLAG_C] = cy;
          next_flags[FLAG_H] = is_sub ? ~hc : hc;
        end
      end
      OP_ADDR_PLUS, OP_ADDR_MINUS: begin
        next_dst  = addr_res;
        write_dst = 1'b1;
      end
      OP_DEC_ADJ_PLUS, OP_DEC_ADJ_MIN: begin
        next_dst  = merge(SIZE_BYTE, dst_val, {24'h0, bcd_res});
        write_dst = 1'b1;
        next_flags[FLAG_N] = bcd_res[7];
        next_flags[FLAG_Z] = (bcd_res == 8'h00);
        next_flags[FLAG_C] = fix_hi;
      end
      OP_MUL_U: begin
        next_dst  = (sz == SIZE_BYTE) ? merge(SIZE_WORD, dst_val, mul_u) : mul_u;
        write_dst = 1'b1;
      end
      OP_MUL_S: begin
        next_dst  = (sz == SIZE_BYTE) ? merge(SIZE_WORD, dst_val, mul_s) : mul_s;
        write_dst = 1'b1;
        next_flags[FLAG_N] = (sz == SIZE_BYTE) ? mul_s[15] : mul_s[31];
        next_flags[FLAG_Z] = (sz == SIZE_BYTE) ? (mul_s[15:0] == 16'h0) : (mul_s == 32'h0);
      end
      OP_DIV_U: begin
        next_dst  = (sz == SIZE_BYTE) ? merge(SIZE_WORD, dst_val, div_u) : div_u;
        write_dst = 1'b1;
        next_flags[FLAG_N] = top_bit(sz, dvs_s);
        next_flags[FLAG_Z] = dvs_zero;
      end
      OP_DIV_S: begin
        next_dst  = (sz == SIZE_BYTE) ? merge(SIZE_WORD, dst_val, div_s) : div_s;
        write_dst = 1'b1;
        next_flags[FLAG_N] = div_res_n;
        next_flags[FLAG_Z] = dvs_zero;
      end
      OP_SIGN_EXT, OP_ZERO_EXT: begin
        next_dst  = (issue.op == OP_SIGN_EXT) ? ext_s : ext_z;
        write_dst = 1'b1;
        next_flags[FLAG_N] = (issue.op == OP_SIGN_EXT) && top_bit(sz, ext_s);
        next_flags[FLAG_Z] = (size_mask(sz, next_dst) == 32'h0);
        next_flags[FLAG_V] = 1'b0;
      end
      default: begin
        write_dst = 1'b0;
      end
    endcase
  end

  // Memory request and the stack-pointer update that goes with it
  wire logic is_mem   = (issue.op == OP_LOAD_MEM) || (issue.op == OP_STORE_MEM) ||
                        (issue.op == OP_POP) || (issue.op == OP_PUSH);
  wire logic [31:0] push_addr = sp_val - stack_step;
  wire logic [31:0] mem_addr  = (issue.op == OP_POP) ? sp_val :
                                (issue.op == OP_PUSH) ? push_addr : src_val;
  wire logic mem_wr   = (issue.op == OP_STORE_MEM) || (issue.op == OP_PUSH);
  wire logic [31:0] store_val = (issue.op == OP_PUSH) ? regs[issue.src] : dst_val;
  wire logic held_load = (held.op == OP_LOAD_MEM) || (held.op == OP_POP);
  wire logic stk_op    = (issue.op == OP_POP) || (issue.op == OP_PUSH);
  wire logic mem_done  = (state == ST_MEM) && mem_rsp.done;
  wire logic [31:0] sp_next = (issue.op == OP_POP) ? sp_val + stack_step : push_addr;

  // Sequencing: memory operations wait for the bus answer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ST_IDLE;
    end else if (exec && is_mem) begin
      state <= ST_MEM;
    end else if ((state == ST_MEM) && mem_rsp.done) begin
      state <= ST_IDLE;
    end
  end

  // Held copy of a memory instruction during the bus wait
  always_ff @(posedge core_clk) begin
    if (rst) begin
      held <= '0;
    end else if (exec && is_mem) begin
      held <= issue;
    end
  end

  // Register file; the stack pointer moves at issue, the load lands at the answer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        regs[i] <= REG_RESET;
      end
    end else if (mem_done && held_load) begin
      regs[held.dst] <= merge(held.size, regs[held.dst], mem_rsp.rdata);
    end else if (exec && stk_op) begin
      regs[STACK_REG_IDX] <= sp_next;
    end else if (exec && write_dst) begin
      regs[issue.dst] <= next_dst;
    end
  end

  // Flags, ready, refusal strobe and bus request; ready mirrors the sequencer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flags       <= {1'b0, FLAGS_RESET};
      issue_ready <= 1'b1;
      illegal_op  <= 1'b0;
      mem_req     <= '0;
    end else begin
      illegal_op <= take && reject;
      if (exec) flags <= next_flags;
      if (exec && is_mem) begin
        issue_ready <= 1'b0;
        mem_req     <= '{req: 1'b1, write: mem_wr, size: sz, addr: mem_addr, wdata: store_val};
      end else if (mem_done) begin
        issue_ready <= 1'b1;
        mem_req.req <= 1'b0;
      end
    end
  end

  // Outputs leave straight from the flag and stack registers
  assign condition_flags = flags;
  assign stack_pointer   = regs[STACK_REG_IDX];

  // Checks on handshake, stack pointer and refusals
  default clocking chk_cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_ready_idle;
    issue_ready == (state == ST_IDLE);
  endproperty
  a_ready_idle: assert property (p_ready_idle) else $error("ready off");

  property p_req_hold;
    mem_req.req && !mem_rsp.done |=> mem_req.req && $stable(mem_req.addr);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped");

  property p_refuse_flags;
    take && reject |=> $stable(flags);
  endproperty
  a_refuse_flags: assert property (p_refuse_flags) else $error("flags moved");

  property p_refuse_strobe;
    take && reject |=> illegal_op;
  endproperty
  a_refuse_strobe: assert property (p_refuse_strobe) else $error("no refusal");

  property p_push_sp;
    exec && (issue.op == OP_PUSH) |=> stack_pointer == $past(push_addr);
  endproperty
  a_push_sp: assert property (p_push_sp) else $error("push pointer");

  property p_pop_sp;
    exec && (issue.op == OP_POP) |=> stack_pointer == $past(sp_val + stack_step);
  endproperty
  a_pop_sp: assert property (p_pop_sp) else $error("pop pointer");

  // Scenarios worth seeing
  c_mem_wait: cover property (mem_req.req && !mem_rsp.done);
  c_refused: cover property (take && reject);
  c_carry: cover property (exec && use_cy);

endmodule : xfer_arith_unit

//--- tb/test_cpu_transfer_arith_datapath.sv
// Self-checking random bench for the transfer and arithmetic execution unit
`timescale 1ns/1ps
module test_cpu_transfer_arith_datapath
  import xfer_arith_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic        issue_valid = 1'b0;
  issue_t      issue = '0;
  mem_rsp_t    mem_rsp = '0;
  logic        issue_ready;
  logic        illegal_op;
  mem_req_t    mem_req;
  logic [4:0]  condition_flags;
  logic [31:0] stack_pointer;
  logic [31:0] exp_r [8];
  logic [31:0] mem [logic [31:0]];
  logic [31:0] w_addr, w_data;
  int          fail_count = 0, compares = 0, cycles = 0, nreq = 0, nill = 0, wait_cnt = 0;

  xfer_arith_unit i_xfer_arith_unit (
    .core_clk(core_clk), .issue(issue), .issue_valid(issue_valid), .mem_rsp(mem_rsp),
    .rst(rst), .issue_ready(issue_ready), .illegal_op(illegal_op), .mem_req(mem_req),
    .condition_flags(condition_flags), .stack_pointer(stack_pointer));

  initial begin
    forever #20 core_clk = ~core_clk;
  end

  // Memory answers after 0 to 3 idle cycles, junk data otherwise
  always @(posedge core_clk) begin
    #1;
    mem_rsp.rdata = $urandom;
    if (mem_rsp.done === 1'b1 || rst === 1'b1) begin
      mem_rsp.done = 1'b0;
    end else if (mem_req.req === 1'b1) begin
      if (wait_cnt == 0) begin
        mem_rsp.done = 1'b1;
        mem_rsp.rdata = mem.exists(mem_req.addr) ? mem[mem_req.addr] : 32'h0000_0000;
        if (mem_req.write === 1'b1) mem[mem_req.addr] = mem_req.wdata;
        w_addr = mem_req.addr;
        w_data = mem_req.wdata;
        nreq++;
        wait_cnt = $urandom_range(3, 0);
      end else wait_cnt--;
    end
  end

  // Hang guard and refusal counter, mid-cycle so strobes are settled
  always @(negedge core_clk) begin
    cycles++;
    if (illegal_op === 1'b1) nill++;
    if (cycles == 40000) begin
      fail_count++;
      close_out();
    end
  end

  function automatic logic [31:0] msk(input op_size_t s);
    return (s == SIZE_BYTE) ? 32'h0000_00ff : (s == SIZE_WORD) ? 32'h0000_ffff : 32'hffff_ffff;
  endfunction : msk

  function automatic logic [31:0] put(input logic [31:0] o, input op_size_t s, input logic [31:0] v);
    return (o & ~msk(s)) | (v & msk(s));
  endfunction : put

  function automatic longint sx(input longint v, input int w);
    return v[w-1] ? v - (longint'(1) << w) : v;
  endfunction : sx

  // Sized add or subtract; flags sit above the 32-bit result
  function automatic logic [36:0] addsub(input logic [31:0] a, b, input logic c, sub,
                                         input op_size_t s);
    logic [32:0] f;
    logic [31:0] m, r, t;
    logic [4:0]  fl;
    m = msk(s);
    f = sub ? {1'b0, a & m} - {1'b0, b & m} - c : {1'b0, a & m} + {1'b0, b & m} + c;
    r = f[31:0] & m;
    t = (m >> 1) + 32'h1;
    fl = 5'h00;
    fl[FLAG_C] = f[(s == SIZE_BYTE) ? 8 : (s == SIZE_WORD) ? 16 : 32];
    fl[FLAG_N] = |(r & t);
    fl[FLAG_Z] = (r == 32'h0);
    fl[FLAG_V] = ((|(a & t)) != ((|(b & t)) ^ sub)) ? 1'b0 : ((|(r & t)) != (|(a & t)));
    return {fl, r};
  endfunction : addsub

  // Products and packed remainder:quotient on the low 2w bits
  function automatic logic [31:0] muldiv(input op_code_t op, input op_size_t s,
                                         input logic [31:0] a, b);
    longint mw, x, y, q;
    int     w;
    w = (s == SIZE_BYTE) ? 8 : 16;
    mw = (longint'(1) << w) - 1;
    if (op == OP_MUL_U) q = (a & mw) * (b & mw);
    else if (op == OP_MUL_S) q = sx(a & mw, w) * sx(b & mw, w);
    else begin
      x = (op == OP_DIV_S) ? sx(a & ((mw << w) | mw), 2 * w) : a & ((mw << w) | mw);
      y = (op == OP_DIV_S) ? sx(b & mw, w) : b & mw;
      q = (((x % y) & mw) << w) | ((x / y) & mw);
    end
    return 32'(q & ((mw << w) | mw));
  endfunction : muldiv

  task automatic check(input logic [31:0] seen, input logic [31:0] expv);
    compares++;
    if (seen !== expv) begin
      fail_count++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, expv);
    end
  endtask : check

  task automatic fl(input logic [4:0] e);
    check({27'h0, condition_flags & 5'h0f}, {27'h0, e});
  endtask : fl

  task automatic close_out;
    if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : close_out

  // Holds the request until taken, then waits for the unit to be free again
  task automatic run_op(input op_code_t op, input op_size_t s, input logic [2:0] d, sr,
                        input logic ui, input logic [31:0] im);
    int   n;
    logic rdy;
    @(posedge core_clk);
    #1;
    issue = '{op: op, size: s, dst: d, src: sr, use_imm: ui, imm: im};
    issue_valid = 1'b1;
    n = 0;
    do begin
      rdy = issue_ready; // Settled value, as the next edge sees it
      @(posedge core_clk);
      n++;
    end while (rdy !== 1'b1 && n < 100);
    #1;
    issue_valid = 1'b0;
    issue.imm = $urandom;
    n = 0;
    while (issue_ready !== 1'b1 && n < 100) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    repeat (2) @(posedge core_clk);
    #1;
  endtask : run_op

  task automatic setr(input logic [2:0] r, input logic [31:0] v);
    run_op(OP_MOVE_IMM, SIZE_LONG, r, 3'h0, 1'b1, v);
    exp_r[r] = v;
  endtask : setr

  // Reads a register back by pushing it as a longword
  task automatic peek(input logic [2:0] r, output logic [31:0] v);
    int k;
    k = nreq;
    run_op(OP_PUSH, SIZE_LONG, r, r, 1'b0, 32'h0);
    exp_r[7] = exp_r[7] - STEP_LONG;
    check(w_addr, exp_r[7]);
    check(stack_pointer, exp_r[7]);
    check(32'(nreq - k), 32'h1);
    v = w_data;
  endtask : peek

  initial begin
    logic [31:0] a, b, v, e, aa, bb, mw, m2;
    logic [36:0] r;
    logic        cin;
    op_size_t    s;
    op_code_t    op;
    int          j, k, m, n0, w;
    op_code_t    ar_ops [5] = '{OP_PLUS, OP_MINUS, OP_COMPARE, OP_PLUS, OP_MINUS};
    op_code_t    bad_ops [3] = '{OP_PERIPH_READ, OP_PERIPH_WRITE, OP_MINUS};
    logic [31:0] ca [4] = '{32'h7f7f_7fff, 32'h8000_0080, 32'h0000_0000, 32'hffff_ffff};
    logic [31:0] cb [4] = '{32'h0000_0001, 32'h8000_0001, 32'h0000_0000, 32'h0000_0001};
    void'($urandom(7488));
    exp_r = '{default: REG_RESET};
    repeat (4) @(posedge core_clk);
    #1;
    rst = 1'b0;
    check(stack_pointer, REG_RESET);
    check({27'h0, condition_flags}, {27'h0, 1'b0, FLAGS_RESET});
    setr(3'h7, 32'h0000_4000);
    for (j = 0; j < 16; j++) begin
      a = (j < 4) ? ca[j] : $urandom;
      b = (j < 4) ? cb[j] : $urandom;
      setr(3'h1, a);
      setr(3'h2, b);
      for (k = 0; k < 3; k++) begin
        s = op_size_t'(k);
        for (m = 0; m < 5; m++) begin
          if (m == 4 && k == 0) continue;
          setr(3'h3, a);
          run_op(ar_ops[m], s, 3'h3, (m > 2) ? 3'h4 : 3'h2, m > 2, b);
          r = addsub(a, b, 1'b0, ar_ops[m] != OP_PLUS, s);
          fl(r[36:32]);
          peek(3'h3, v);
          check(v, (m == 2) ? a : put(a, s, r[31:0]));
        end
        setr(3'h3, a);
        run_op(OP_NEGATE, s, 3'h3, 3'h3, 1'b0, 32'h0);
        r = addsub(32'h0, a, 1'b0, 1'b1, s);
        fl(r[36:32]);
        peek(3'h3, v);
        check(v, put(a, s, r[31:0]));
        setr(3'h3, b);
        run_op(OP_MOVE_REG, s, 3'h3, 3'h1, 1'b0, 32'h0);
        peek(3'h3, v);
        check(v, put(b, s, a));
        run_op(OP_MOVE_IMM, s, 3'h3, 3'h0, 1'b1, b);
        peek(3'h3, v);
        check(v, b);
      end
      // Carry chain: compare seeds the carry, each carry op feeds the next
      setr(3'h3, a);
      run_op(OP_COMPARE, SIZE_BYTE, 3'h3, 3'h2, 1'b0, 32'h0);
      r = addsub(a, b, 1'b0, 1'b1, SIZE_BYTE);
      cin = r[32+FLAG_C];
      run_op(OP_PLUS_CARRY, SIZE_BYTE, 3'h3, 3'h2, 1'b0, 32'h0);
      r = addsub(a, b, cin, 1'b0, SIZE_BYTE);
      e = put(a, SIZE_BYTE, r[31:0]);
      cin = r[32+FLAG_C];
      run_op(OP_MINUS_BORROW, SIZE_BYTE, 3'h3, 3'h4, 1'b1, b);
      r = addsub(e, b, cin, 1'b1, SIZE_BYTE);
      peek(3'h3, v);
      check(v, put(e, SIZE_BYTE, r[31:0]));
      // Nonzero divisors, quotients kept in range
      for (k = 0; k < 2; k++) begin
        s = op_size_t'(k);
        w = k ? 16 : 8;
        mw = msk(s);
        m2 = msk(op_size_t'(k + 1));
        for (m = 0; m < 4; m++) begin
          op = op_code_t'(5'h11 + m);
          aa = a;
          bb = b;
          if (op == OP_DIV_U) begin
            bb = (b & mw) | 32'h1;
            aa = ((((a >> w) & mw) % bb) << w) | (a & mw);
          end else if (op == OP_DIV_S) begin
            bb = ((b & mw) == 32'h0 || (b & mw) == mw) ? 32'h1 : (b & mw);
            aa = a[w-1] ? (a | ~mw) : (a & mw);
          end
          e = (a & ~m2) | (aa & m2);
          setr(3'h3, e);
          setr(3'h2, bb);
          run_op(op, s, 3'h3, 3'h2, 1'b0, 32'h0);
          peek(3'h3, v);
          check(v, put(e, op_size_t'(k + 1), muldiv(op, s, e, bb)));
        end
      end
      for (k = 1; k < 3; k++) begin
        for (m = 0; m < 2; m++) begin
          setr(3'h3, a);
          run_op(m ? OP_ZERO_EXT : OP_SIGN_EXT, op_size_t'(k), 3'h3, 3'h3, 1'b0, 32'h0);
          e = (k == 1) ? {a[31:16], {8{a[7] & !m}}, a[7:0]} : {{16{a[15] & !m}}, a[15:0]};
          peek(3'h3, v);
          check(v, e);
        end
      end
      setr(3'h4, b);
      run_op(OP_PUSH, SIZE_WORD, 3'h1, 3'h1, 1'b0, 32'h0);
      exp_r[7] = exp_r[7] - STEP_WORD;
      check(w_addr, exp_r[7]);
      run_op(OP_POP, SIZE_WORD, 3'h4, 3'h4, 1'b0, 32'h0);
      check(w_addr, exp_r[7]);
      exp_r[7] = exp_r[7] + STEP_WORD;
      check(stack_pointer, exp_r[7]);
      peek(3'h4, v);
      check(v, put(b, SIZE_WORD, a));
      // Refused operations leave registers, flags and memory alone
      for (m = 0; m < 3; m++) begin
        setr(3'h3, a);
        run_op(OP_COMPARE, SIZE_LONG, 3'h3, 3'h2, 1'b0, 32'h0);
        r = addsub(a, exp_r[2], 1'b0, 1'b1, SIZE_LONG);
        k = nreq;
        n0 = nill;
        run_op(bad_ops[m], SIZE_BYTE, 3'h3, 3'h2, m == 2, b);
        check(32'(nill != n0), 32'h1);
        check(32'(nreq - k), 32'h0);
        fl(r[36:32]);
        peek(3'h3, v);
        check(v, a);
      end
    end
    close_out();
  end
endmodule : test_cpu_transfer_arith_datapath
